// ### logic/pgd_pkg.sv
// Shared constants and types for the power-good delay and reset supervisor.
package pgd_pkg;

  // ==========================================================================
  // Clock and time base.
  // ==========================================================================
  localparam int CLK_HZ      = 100_000_000;  // Reference clock rate in hertz.
  localparam int TICK_US     = 10;           // Timer tick period in microseconds.
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;  // Cycles per tick.
  localparam int TICK_W      = 10;           // Width of the tick divider.

  // ==========================================================================
  // Release delay and mask window, in microseconds and in ticks.
  // ==========================================================================
  localparam int DLY_50US_US  = 50;
  localparam int DLY_50MS_US  = 50_000;
  localparam int DLY_100MS_US = 100_000;
  localparam int DLY_200MS_US = 200_000;
  localparam int MASK_5MS_US  = 5_000;
  localparam int DLY_50US_TK  = DLY_50US_US / TICK_US;
  localparam int DLY_50MS_TK  = DLY_50MS_US / TICK_US;
  localparam int DLY_100MS_TK = DLY_100MS_US / TICK_US;
  localparam int DLY_200MS_TK = DLY_200MS_US / TICK_US;
  localparam int MASK_TK      = MASK_5MS_US / TICK_US;
  localparam int DCNT_W       = 15;          // Holds the longest delay in ticks.
  localparam int MCNT_W       = 10;          // Holds the mask window in ticks.

  // Delay select codes; the reset value picks the shortest delay.
  localparam logic [1:0] SEL_50US  = 2'h0;
  localparam logic [1:0] SEL_50MS  = 2'h1;
  localparam logic [1:0] SEL_100MS = 2'h2;
  localparam logic [1:0] SEL_200MS = 2'h3;
  localparam logic [1:0] SEL_RESET = SEL_50US;

  // ==========================================================================
  // Comparator thresholds.
  // ==========================================================================
  localparam int          LVL_W      = 8;       // Output level, percent of target.
  localparam logic [7:0]  RDY_SET    = 8'h5E;   // In range above 94 percent.
  localparam logic [7:0]  RDY_CLR    = 8'h55;   // Out of range below 85 percent.
  localparam logic [7:0]  GOOD_SET   = 8'h5B;   // Rising path needs 91 percent.
  localparam logic [7:0]  GOOD_CLR   = 8'h52;   // Falling path trips at 82 percent.
  localparam int          MV_W       = 12;      // Raw input supply in millivolts.
  localparam logic [11:0] UVLO_TRIP  = 12'hAF0; // 2800 mV trip point.
  localparam logic [11:0] UVLO_HYST  = 12'h064; // 100 mV of hysteresis.

  // ==========================================================================
  // Types.
  // ==========================================================================
  typedef enum logic [1:0] {PG_IDLE, PG_DELAY, PG_RELEASED, PG_FAIL} pgd_state_t;

  // Power stage controls of one buck converter.
  typedef struct packed {
    logic high_side_on;   // High-side switch enabled.
    logic low_side_on;    // Low-side switch discharging the output.
    logic bias_on;        // Reference, control and bias powered.
    logic soft_start;     // One-cycle pulse starting soft start.
  } pgd_drive_t;

endpackage

// ### logic/pgd_sync.sv
// Two-flop synchroniser, one chain per bit.
`timescale 1ns/1ps
`default_nettype none
module pgd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  import pgd_pkg::*;

  // All state: first and second stage of every chain.
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pgd_sync_t;

  pgd_sync_t s_q;  // Registered state.
  pgd_sync_t s_d;  // Next state.

  // ==========================================================================
  // Per-bit chains; stage one is read only by stage two.
  // ==========================================================================
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      s_d.s1[i] = din[i];
      s_d.s2[i] = s_q.s1[i];
    end
  end

  // Register the chains; reset clears them to a constant.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.s2;
endmodule
`default_nettype wire

// ### logic/pgd_hyst.sv
// Comparator with hysteresis: sets above one threshold, clears below another.
`timescale 1ns/1ps
`default_nettype none
module pgd_hyst #(
  parameter int               W      = 8,
  parameter logic [W-1:0]     SET_TH = '1,
  parameter logic [W-1:0]     CLR_TH = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] level,
  output logic              above
);
  import pgd_pkg::*;

  logic q;  // Registered comparator state.
  logic d;  // Next comparator state.

  // Between the thresholds the old state holds, so a level near the trip
  // point cannot chatter.
  always_comb begin
    d = q;
    if (level > SET_TH) begin
      d = 1'b1;
    end else if (level < CLR_TH) begin
      d = 1'b0;
    end
  end

  // Reset starts below the trip point.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign above = q;
endmodule
`default_nettype wire

// ### logic/pgd_top.sv
// Power-good with delay supervisor, undervoltage lockout and buck shutdown.
// Functional notes
// - Output low below 91 rising, 82 falling.
// - Delay 50us/50ms/100ms/200ms, resets to 50us.
// - Open-drain output: pull low or release.
// - In-range sets above 94, clears below 85.
// - Enabled in-range rise starts delay, then release.
// - Other converter ignored while delay runs.
// - Falling in-range after release retriggers delay.
// - Other rail missing at delay end: stay low.
// - Late enable starts 5 ms mask, output high.
// - After mask, follow both in-range signals.
// - Delay reset by reset and enables; set otherwise.
// - Mask terms and delay ANDed into output.
// - Low raw supply disables all four regulators.
// - Supply-ok gates the four regulator enables.
// - Supply-ok detector has hysteresis.
// - Shutdown: high side, bias off; low side on.
// - Enabling a converter starts soft start.
`timescale 1ns/1ps
`default_nettype none
module pgd_top #(
  parameter int DLY_50US_TICKS  = pgd_pkg::DLY_50US_TK,
  parameter int DLY_50MS_TICKS  = pgd_pkg::DLY_50MS_TK,
  parameter int DLY_100MS_TICKS = pgd_pkg::DLY_100MS_TK,
  parameter int DLY_200MS_TICKS = pgd_pkg::DLY_200MS_TK,
  parameter int MASK_TICKS      = pgd_pkg::MASK_TK,
  parameter int TICK_CYC        = pgd_pkg::TICK_CYCLES
) (
  input  wire logic                     REF_CLK,
  input  wire logic                     RESET_N,
  input  wire logic                     FIRST_CONVERTER_ENABLE,
  input  wire logic                     SECOND_CONVERTER_ENABLE,
  input  wire logic                     FIRST_LDO_ENABLE,
  input  wire logic                     SECOND_LDO_ENABLE,
  input  wire logic [pgd_pkg::LVL_W-1:0] FIRST_OUTPUT_LEVEL,
  input  wire logic [pgd_pkg::LVL_W-1:0] SECOND_OUTPUT_LEVEL,
  input  wire logic [pgd_pkg::MV_W-1:0]  RAW_INPUT_SUPPLY_MV,
  input  wire logic [1:0]               DELAY_SELECT,
  input  wire logic                     POWER_GOOD_N_IN,
  output logic                          POWER_GOOD_N_OUT,
  output logic                          POWER_GOOD_N_OE,
  output logic                          SUPPLY_OK,
  output logic                          FIRST_CONVERTER_IN_RANGE,
  output logic                          SECOND_CONVERTER_IN_RANGE,
  output pgd_pkg::pgd_drive_t           FIRST_BUCK_DRIVE,
  output pgd_pkg::pgd_drive_t           SECOND_BUCK_DRIVE,
  output logic                          FIRST_LDO_RUN,
  output logic                          SECOND_LDO_RUN
);
  import pgd_pkg::*;

  // ==========================================================================
  // Monitors: in-range, power-good window and supply-ok comparators.
  // ==========================================================================
  logic [1:0]       rdy_raw;    // In-range comparators, before sync.
  logic [1:0]       good;       // 91/82 percent window comparators.
  logic             supply_ok;  // Raw supply above the lockout trip point.
  logic [LVL_W-1:0] lvl [2];    // Output levels by converter index.

  assign lvl[0] = FIRST_OUTPUT_LEVEL;
  assign lvl[1] = SECOND_OUTPUT_LEVEL;

  // The pin returned from the wire is not needed; the driver knows its state.
  logic unused_pin;
  assign unused_pin = POWER_GOOD_N_IN;

  for (genvar i = 0; i < 2; i++) begin : g_conv
    // In-range flag with 94/85 percent hysteresis.
    pgd_hyst #(.W(LVL_W), .SET_TH(RDY_SET), .CLR_TH(RDY_CLR)) u_rdy (
      .clk   (REF_CLK),
      .rst_n (RESET_N),
      .level (lvl[i]),
      .above (rdy_raw[i])
    );
    // Power-good window: needs 91 percent rising, trips at 82.
    pgd_hyst #(.W(LVL_W), .SET_TH(GOOD_SET), .CLR_TH(GOOD_CLR)) u_good (
      .clk   (REF_CLK),
      .rst_n (RESET_N),
      .level (lvl[i]),
      .above (good[i])
    );
  end

  // Undervoltage detector with hysteresis above the trip point.
  pgd_hyst #(
    .W      (MV_W),
    .SET_TH (12'(UVLO_TRIP + UVLO_HYST)),
    .CLR_TH (UVLO_TRIP)
  ) u_uvlo (
    .clk   (REF_CLK),
    .rst_n (RESET_N),
    .level (RAW_INPUT_SUPPLY_MV),
    .above (supply_ok)
  );

  // ==========================================================================
  // Synchronisers: enables and in-range flags reach the timer clock first.
  // ==========================================================================
  logic [5:0] sync_out;  // Synchronised enables, in-range and LDO enables.
  logic [1:0] en;        // Converter enables.
  logic [1:0] rdy;       // Converter in-range flags.
  logic [1:0] ldo_en;    // LDO enables.

  // Edge detection only ever looks at the second stage.
  pgd_sync #(.W(6)) u_sync (
    .clk   (REF_CLK),
    .rst_n (RESET_N),
    .din   ({SECOND_LDO_ENABLE, FIRST_LDO_ENABLE, rdy_raw,
             SECOND_CONVERTER_ENABLE, FIRST_CONVERTER_ENABLE}),
    .dout  (sync_out)
  );

  assign en     = sync_out[1:0];
  assign rdy    = sync_out[3:2];
  assign ldo_en = sync_out[5:4];

  // ==========================================================================
  // State: one packed struct, filled by one comb process.
  // ==========================================================================
  typedef struct packed {
    pgd_state_t              st;        // Delay timer state.
    logic [1:0]              sel;       // Latched delay select.
    logic [TICK_W-1:0]       tick_cnt;  // Time base divider.
    logic [DCNT_W-1:0]       dcnt;      // Delay counter in ticks.
    logic [1:0][MCNT_W-1:0]  mcnt;      // Mask counters in ticks.
    logic [1:0]              masking;   // Mask window running.
    logic [1:0]              en_prev;   // Enables, one cycle late.
    logic [1:0]              rdy_prev;  // In-range flags, one cycle late.
    logic [1:0]              run_prev;  // Gated buck enables, one cycle late.
    logic                    pg_oe;     // Pulling the power-good line low.
    logic                    sup_ok;    // Registered supply-ok.
    logic [1:0]              rdy_out;   // Registered in-range view.
    pgd_drive_t              drv0;      // First buck power stage.
    pgd_drive_t              drv1;      // Second buck power stage.
    logic [1:0]              ldo_run;   // Gated LDO enables.
  } pgd_regs_t;

  pgd_regs_t s_q;  // Registered state.
  pgd_regs_t s_d;  // Next state.

  // Delay length in ticks for a select code.
  function automatic logic [DCNT_W-1:0] dly_ticks(input logic [1:0] sel);
    case (sel)
      SEL_50US:  dly_ticks = DCNT_W'(DLY_50US_TICKS);
      SEL_50MS:  dly_ticks = DCNT_W'(DLY_50MS_TICKS);
      SEL_100MS: dly_ticks = DCNT_W'(DLY_100MS_TICKS);
      SEL_200MS: dly_ticks = DCNT_W'(DLY_200MS_TICKS);
      default:   dly_ticks = DCNT_W'(DLY_50US_TICKS);
    endcase
  endfunction

  // ==========================================================================
  // Next-state logic.
  // ==========================================================================
  always_comb begin
    logic       tick;      // One-cycle timer tick.
    logic [1:0] rdy_rise;  // In-range rising edges.
    logic [1:0] en_rise;   // Enable rising edges.
    logic [1:0] rail_ok;   // Per converter: disabled, or in range and good.
    logic       set_in;    // Set term of the delay timer.
    logic       clr_in;    // Reset term of the delay timer.
    logic [1:0] run;       // Buck enables gated by supply-ok.
    logic       pg_high;   // Final AND of delay and mask terms.
    tick     = 1'b0;
    rdy_rise = rdy & ~s_q.rdy_prev;
    en_rise  = en & ~s_q.en_prev;
    rail_ok  = ~en | (rdy & good);
    set_in   = |(en & rdy);
    clr_in   = ~(|en);
    run      = en & {2{supply_ok}};
    pg_high  = 1'b0;
    s_d      = s_q;

    // Time base: all delay and mask counts advance on this tick.
    if (s_q.tick_cnt == TICK_W'(TICK_CYC - 1)) begin
      s_d.tick_cnt = '0;
      tick         = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 1'b1;
    end

    s_d.en_prev  = en;
    s_d.rdy_prev = rdy;
    s_d.run_prev = run;

    // With both enables low the timer is held reset; set needs an enable, so
    // set and reset cannot both be true.
    if (clr_in) begin
      s_d.st      = PG_IDLE;
      s_d.dcnt    = '0;
      s_d.masking = '0;
      s_d.mcnt    = '0;
    end else begin
      case (s_q.st)
        // Waiting, or failed: an enabled rail coming into range starts the
        // delay; the select is latched then so it cannot shift mid-count.
        PG_IDLE, PG_FAIL: begin
          if (set_in && |(rdy_rise & en)) begin
            s_d.st   = PG_DELAY;
            s_d.dcnt = '0;
            s_d.sel  = DELAY_SELECT;
          end
        end
        // Counting: activity of the other converter is not looked at.
        PG_DELAY: begin
          s_d.masking = '0;
          if (tick) begin
            if (s_q.dcnt >= dly_ticks(s_q.sel) - 1'b1) begin
              // A rail that never came valid leaves the line low.
              s_d.st = (&rail_ok) ? PG_RELEASED : PG_FAIL;
            end else begin
              s_d.dcnt = s_q.dcnt + 1'b1;
            end
          end
        end
        // Released: late enables open a mask; an unmasked rail dropping
        // out pulls the line low and retriggers the delay.
        PG_RELEASED: begin
          for (int i = 0; i < 2; i++) begin
            if (en_rise[i]) begin
              s_d.masking[i] = 1'b1;
              s_d.mcnt[i]    = '0;
            end else if (s_q.masking[i] && tick) begin
              if (s_q.mcnt[i] >= MCNT_W'(MASK_TICKS - 1)) begin
                s_d.masking[i] = 1'b0;
              end else begin
                s_d.mcnt[i] = s_q.mcnt[i] + 1'b1;
              end
            end
          end
          // A mask opened in this very cycle already covers its late rail.
          if (|(~rail_ok & ~s_d.masking)) begin
            s_d.st      = PG_DELAY;
            s_d.dcnt    = '0;
            s_d.sel     = DELAY_SELECT;
            s_d.masking = '0;
          end
        end
        default: begin
          s_d.st = PG_IDLE;
        end
      endcase
    end

    // Delay output ANDed with each mask term.
    pg_high = (s_d.st == PG_RELEASED) &&
              (&(s_d.masking | rail_ok));
    s_d.pg_oe = ~pg_high;

    // Lockout gates every regulator enable.
    s_d.sup_ok  = supply_ok;
    s_d.rdy_out = rdy;
    s_d.ldo_run = ldo_en & {2{supply_ok}};

    // Shutdown: high side and bias off, low side discharging; a fresh enable
    // under a good supply starts soft start.
    s_d.drv0.high_side_on = run[0];
    s_d.drv0.bias_on      = run[0];
    s_d.drv0.low_side_on  = ~run[0];
    s_d.drv0.soft_start   = run[0] & ~s_q.run_prev[0];
    s_d.drv1.high_side_on = run[1];
    s_d.drv1.bias_on      = run[1];
    s_d.drv1.low_side_on  = ~run[1];
    s_d.drv1.soft_start   = run[1] & ~s_q.run_prev[1];
  end

  // ==========================================================================
  // State register.  Reset leaves every buck in shutdown and the line low.
  // ==========================================================================
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q                   <= '0;
      s_q.st                <= PG_IDLE;
      s_q.sel               <= SEL_RESET;
      s_q.pg_oe             <= 1'b1;
      s_q.drv0.low_side_on  <= 1'b1;
      s_q.drv1.low_side_on  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs: pin data tied low, all others straight from the state register.
  // ==========================================================================
  assign POWER_GOOD_N_OUT          = 1'b0;
  assign POWER_GOOD_N_OE           = s_q.pg_oe;
  assign SUPPLY_OK                 = s_q.sup_ok;
  assign FIRST_CONVERTER_IN_RANGE  = s_q.rdy_out[0];
  assign SECOND_CONVERTER_IN_RANGE = s_q.rdy_out[1];
  assign FIRST_BUCK_DRIVE          = s_q.drv0;
  assign SECOND_BUCK_DRIVE         = s_q.drv1;
  assign FIRST_LDO_RUN             = s_q.ldo_run[0];
  assign SECOND_LDO_RUN            = s_q.ldo_run[1];
endmodule
`default_nettype wire

// ### verification/pgd_top_sva.sv
// Assertion checker for the power-good supervisor top level.
`timescale 1ns/1ps
`default_nettype none
module pgd_top_sva (
  input wire logic                  REF_CLK,
  input wire logic                  RESET_N,
  input wire logic                  FIRST_CONVERTER_ENABLE,
  input wire logic                  SECOND_CONVERTER_ENABLE,
  input wire logic [7:0]            FIRST_OUTPUT_LEVEL,
  input wire logic [11:0]           RAW_INPUT_SUPPLY_MV,
  input wire logic                  POWER_GOOD_N_OUT,
  input wire logic                  POWER_GOOD_N_OE,
  input wire logic                  SUPPLY_OK,
  input wire logic                  FIRST_CONVERTER_IN_RANGE,
  input wire pgd_pkg::pgd_drive_t   FIRST_BUCK_DRIVE,
  input wire logic                  FIRST_LDO_RUN
);
  // ==========================================================================
  // Properties, all on the reference clock.
  // ==========================================================================
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  // The pin data is fixed low; only the enable may move the line.
  property p_od_low; POWER_GOOD_N_OUT == 1'b0; endproperty
  a_od_low: assert property (p_od_low) else $error("open drain data not low");
  // A lost supply must stop the LDO within the register latency.
  property p_ldo_gate; !SUPPLY_OK [*3] |-> !FIRST_LDO_RUN; endproperty
  a_ldo_gate: assert property (p_ldo_gate) else $error("LDO runs without supply");
  property p_buck_off;
    !SUPPLY_OK [*4] |-> !FIRST_BUCK_DRIVE.high_side_on && FIRST_BUCK_DRIVE.low_side_on;
  endproperty
  a_buck_off: assert property (p_buck_off) else $error("buck not shut down");
  // Soft start is a single-cycle pulse.
  property p_ss_pulse; FIRST_BUCK_DRIVE.soft_start |=> !FIRST_BUCK_DRIVE.soft_start; endproperty
  a_ss_pulse: assert property (p_ss_pulse) else $error("soft start too long");
  property p_idle_low;
    (!FIRST_CONVERTER_ENABLE && !SECOND_CONVERTER_ENABLE) [*5] |-> POWER_GOOD_N_OE;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("line released while disabled");
  property p_rng_set; (FIRST_OUTPUT_LEVEL > 8'h5E) [*5] |-> FIRST_CONVERTER_IN_RANGE; endproperty
  a_rng_set: assert property (p_rng_set) else $error("in range flag not set");
  property p_uv_clr; (RAW_INPUT_SUPPLY_MV < 12'h0AF0) [*3] |-> !SUPPLY_OK; endproperty
  a_uv_clr: assert property (p_uv_clr) else $error("supply ok below trip");
  property p_uv_set; (RAW_INPUT_SUPPLY_MV > 12'h0B54) [*3] |-> SUPPLY_OK; endproperty
  a_uv_set: assert property (p_uv_set) else $error("supply ok missing");
  // Even the shortest delay spans more than twelve cycles with ticks of four.
  property p_rel_delay; $fell(POWER_GOOD_N_OE) |-> $past(POWER_GOOD_N_OE, 12); endproperty
  a_rel_delay: assert property (p_rel_delay) else $error("release without delay");
  c_release: cover property ($fell(POWER_GOOD_N_OE));
  c_retrig: cover property ($rose(POWER_GOOD_N_OE));
  c_soft: cover property (FIRST_BUCK_DRIVE.soft_start);
endmodule
bind pgd_top pgd_top_sva i_pgd_top_sva (
  .REF_CLK(REF_CLK), .RESET_N(RESET_N),
  .FIRST_CONVERTER_ENABLE(FIRST_CONVERTER_ENABLE), .SECOND_CONVERTER_ENABLE(SECOND_CONVERTER_ENABLE),
  .FIRST_OUTPUT_LEVEL(FIRST_OUTPUT_LEVEL), .RAW_INPUT_SUPPLY_MV(RAW_INPUT_SUPPLY_MV),
  .POWER_GOOD_N_OUT(POWER_GOOD_N_OUT), .POWER_GOOD_N_OE(POWER_GOOD_N_OE), .SUPPLY_OK(SUPPLY_OK),
  .FIRST_CONVERTER_IN_RANGE(FIRST_CONVERTER_IN_RANGE), .FIRST_BUCK_DRIVE(FIRST_BUCK_DRIVE),
  .FIRST_LDO_RUN(FIRST_LDO_RUN)
);
`default_nettype wire

// ### verification/pgd_reset_sink.sv
// Processor reset input on the pulled-up open-drain power-good line.
`timescale 1ns/1ps
`default_nettype none
module pgd_reset_sink (
  input  wire logic drv_oe,  // High while the supervisor pulls the line.
  input  wire logic drv_out, // Data the supervisor would drive.
  output logic      line     // Resolved wire level seen by the processor.
);
  // ==========================================================================
  // Wire resolution.
  // ==========================================================================
  // Nobody else drives the line, so a released line sits at the pull-up.
  assign line = drv_oe ? drv_out : 1'b1;
endmodule
`default_nettype wire

// ### verification/test_pgd_top.sv
// Self-checking testbench for the power-good supervisor.
`timescale 1ns/1ps
`default_nettype none
module test_pgd_top;
  import pgd_pkg::*;
  // ==========================================================================
  // Shortened timers keep every delay within a few hundred cycles.
  // ==========================================================================
  localparam int TC = 4;               // Cycles per timer tick.
  localparam int DTK [4] = '{5, 20, 40, 80};
  typedef struct { logic [1:0] sel; int lag; int lo; int hi; } pgd_row_t;
  // Release window from the first enable: at least N-1 ticks, at most N ticks plus latency.
  pgd_row_t rows [4] = '{'{2'h0, 0, 16, 28}, '{2'h1, 30, 76, 88}, '{2'h2, 0, 156, 168}, '{2'h3, 50, 316, 328}};
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic en1 = 1'b0, en2 = 1'b0, ldo1 = 1'b1, ldo2 = 1'b1;
  logic [7:0] lvl1 = 8'h00, lvl2 = 8'h00;
  logic [11:0] raw_mv = 12'h0BB8;      // 3000 mV, well above the trip point.
  logic [1:0] dsel = SEL_RESET;
  logic pg_line, pg_out, pg_oe, sup_ok, rng1, rng2, run1, run2;
  pgd_drive_t drv1, drv2;
  int err_count = 0;
  int check_count = 0;
  int n;
  always #5 ref_clk = ~ref_clk;
  pgd_top #(.DLY_50US_TICKS(DTK[0]), .DLY_50MS_TICKS(DTK[1]), .DLY_100MS_TICKS(DTK[2]),
    .DLY_200MS_TICKS(DTK[3]), .MASK_TICKS(10), .TICK_CYC(TC)) i_pgd_top (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .FIRST_CONVERTER_ENABLE(en1), .SECOND_CONVERTER_ENABLE(en2),
    .FIRST_LDO_ENABLE(ldo1), .SECOND_LDO_ENABLE(ldo2), .FIRST_OUTPUT_LEVEL(lvl1),
    .SECOND_OUTPUT_LEVEL(lvl2), .RAW_INPUT_SUPPLY_MV(raw_mv), .DELAY_SELECT(dsel),
    .POWER_GOOD_N_IN(pg_line), .POWER_GOOD_N_OUT(pg_out), .POWER_GOOD_N_OE(pg_oe), .SUPPLY_OK(sup_ok),
    .FIRST_CONVERTER_IN_RANGE(rng1), .SECOND_CONVERTER_IN_RANGE(rng2), .FIRST_BUCK_DRIVE(drv1),
    .SECOND_BUCK_DRIVE(drv2), .FIRST_LDO_RUN(run1), .SECOND_LDO_RUN(run2));
  pgd_reset_sink i_pgd_reset_sink (.drv_oe(pg_oe), .drv_out(pg_out), .line(pg_line));
  // ==========================================================================
  // Helpers.
  // ==========================================================================
  // Inputs always move one nanosecond after the rising edge.
  task automatic step(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s got %b", $time, what, got);
    end
  endtask
  task automatic chk_drv(input pgd_drive_t got, input pgd_drive_t exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t buck drive got %h", $time, got);
    end
  endtask
  task automatic chk_win(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("ERROR %0t release after %0d cycles", $time, got);
    end
  endtask
  // Waits a bounded time for the line to come up.
  task automatic wait_up(input int lim);
    for (n = 0; n < lim && pg_line !== 1'b1; n++) step(1);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #400000;
    err_count++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end
  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial begin
    step(3);
    chk(pg_line, 1'b0, "line in reset");
    chk(sup_ok, 1'b0, "supply ok in reset");
    chk_drv(drv1, 4'h4);
    step(2);
    reset_n = 1'b1;
    step(4);
    chk(sup_ok, 1'b1, "supply ok");
    // Both rails good, every delay code, second enable early or late.
    foreach (rows[i]) begin
      dsel = rows[i].sel;
      lvl1 = 8'h64;
      lvl2 = 8'h64;
      en1 = 1'b1;
      en2 = (rows[i].lag == 0);
      for (n = 0; n < rows[i].hi + 4 && pg_line !== 1'b1; n++) begin
        if (n == rows[i].lag) en2 = 1'b1;
        step(1);
      end
      chk_win(n, rows[i].lo, rows[i].hi);
      chk(rng1 & rng2, 1'b1, "both in range");
      // Disabled bucks discharge, so the next row sees a fresh in-range rise.
      en1 = 1'b0;
      en2 = 1'b0;
      lvl1 = 8'h00;
      lvl2 = 8'h00;
      step(8);
      chk(pg_line, 1'b0, "line after disable");
    end
    // Second rail never comes up: the line must stay low.
    dsel = SEL_50MS;
    lvl1 = 8'h64;
    en1 = 1'b1;
    en2 = 1'b1;
    step(120);
    chk(pg_line, 1'b0, "line with dead rail");
    chk(rng2, 1'b0, "rail two out of range");
    lvl2 = 8'h64;
    wait_up(100);
    chk(pg_line, 1'b1, "release after rail");
    lvl2 = 8'h50;
    step(8);
    chk(pg_line, 0, "line after rail drop");
    lvl2 = 8'h64;
    wait_up(100);
    chk(pg_line, 1'b1, "release after retrigger");
    // A reset in mid-run pulls the line at once; the delay then restarts.
    reset_n = 1'b0;
    step(2);
    chk(pg_line, 1'b0, "line in mid-run reset");
    chk(rng1, 1'b0, "in range in reset");
    reset_n = 1'b1;
    wait_up(100);
    chk(pg_line, 1'b1, "release after reset");
    // Late enable of a dead rail: masked first, then low.
    en2 = 1'b0;
    step(8);
    lvl2 = 8'h00;
    step(8);
    chk(pg_line, 1'b1, "line with rail off");
    en2 = 1'b1;
    step(20);
    chk(pg_line, 1'b1, "line during mask");
    step(40);
    chk(pg_line, 1'b0, "line after mask");
    // Lockout and its hysteresis band.
    raw_mv = 12'h0A8C;
    step(6);
    chk(sup_ok, 1'b0, "supply ok low");
    chk(run1 | run2, 1'b0, "LDO run low");
    chk_drv(drv1, 4'h4);
    chk_drv(drv2, 4'h4);
    raw_mv = 12'h0B22;
    step(6);
    chk(sup_ok, 1'b0, "supply ok in band");
    raw_mv = 12'h0BB8;
    step(6);
    chk(run1 & run2, 1'b1, "LDO run high");
    chk(drv1.high_side_on, 1'b1, "buck running");
    raw_mv = 12'h0B22;
    step(6);
    chk(sup_ok, 1'b1, "supply ok held");
    step(4);
    results();
  end
endmodule
`default_nettype wire
